// ===== src/ndsc_pkg.sv
// Constants, field layouts and carrier types for the node DMA and state control block.
// Assumes a 32-bit APB register bus with one aligned word per 8-bit register.
package ndsc_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_DMA_CONTROL = 8'h00;
   localparam logic [7:0] OFS_REVISION = 8'h04;
   localparam logic [7:0] OFS_NODE_STATE = 8'h08;
   localparam logic [7:0] OFS_MAIN_EVENT = 8'h0C;
   localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h10;
   localparam logic [7:0] OFS_WARN_EVENT = 8'h14;
   localparam logic [7:0] OFS_WARN_MASK = 8'h18;
   localparam logic [7:0] OFS_NODE_STATUS = 8'h1C;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int DMA_SEL_LSB = 0;
   localparam int DMA_SEL_MSB = 2;
   localparam int DMA_TIMING_BIT = 3;
   localparam int DMA_ON_BIT = 7;
   localparam int CLK_DIS_BIT = 7;
   localparam int WARN_SUM_BIT = 0;
   localparam int STAT_RESUME_BIT = 0;
   localparam int STAT_REQ_BIT = 1;
   localparam int STAT_PEND_BIT = 2;
   localparam int STAT_STATE_LSB = 4;
   localparam int STAT_STATE_MSB = 7;

   // ---------------------------------------------------------------
   // Reset values and codes
   // ---------------------------------------------------------------
   localparam logic [7:0] DMA_CONTROL_RST = 8'h00;
   localparam logic [5:0] WARN_MASK_RST = 6'h00;
   localparam logic [2:0] SEL_LAST_LEGAL = 3'h5;
   localparam logic [1:0] NS_BUS_RESET = 2'h0;
   localparam logic [1:0] NS_WAKE = 2'h1;
   localparam logic [1:0] NS_ACTIVE = 2'h2;
   localparam logic [1:0] NS_LOW_POWER = 2'h3;
   // Arbitrary neutral revision value
   localparam logic [3:0] REV_CODE_DEFAULT = 4'hA;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int BUS_RESET_MIN_US = 100;
   localparam int BUS_RESET_MIN_CYC = BUS_RESET_MIN_US * CLK_MHZ;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [3:0]
   {
      NDSC_BUS_RESET = 4'h1,
      NDSC_WAKE = 4'h2,
      NDSC_ACTIVE = 4'h4,
      NDSC_LOW_POWER = 4'h8
   } ndsc_state_e;

   // Endpoint-side status; index 0..2 = EP1,3,5 (tx) or EP2,4,6 (rx)
   typedef struct packed
   {
      logic [2:0] tx_done;
      logic [2:0] tx_final_cmd;
      logic [2:0] rx_last;
      logic [2:0] rx_empty;
      logic [5:0] fifo_warn;
      logic [5:0] ep_enabled;
   } ndsc_ep_s;

endpackage : ndsc_pkg

// ===== src/ndsc_top.sv
// Node DMA request, node functional state and clock output control with APB registers.
// Assumes endpoint status on mclk, async pins (interface select, bus activity) unsynchronised.
//
// Functional notes
// [RULE_01] Clock output disable freezes divided clock pin at its present level.
// [RULE_02] Endpoint select codes 000..101 pick endpoints 1..6; 11x reserved; resets zero.
// [RULE_03] Timing bit 0: request on tx done (EP1,3,5) or rx last (EP2,4,6).
// [RULE_04] Timing bit 1: request when the selected endpoint's FIFO warning is set.
// [RULE_05] Tx completion request holds until done flag cleared or final-packet command set.
// [RULE_06] Tx warning request holds until warning ends or done flag sets.
// [RULE_07] Rx completion request holds until last flag cleared or FIFO empties.
// [RULE_08] Rx warning request holds until warning ends or FIFO empties.
// [RULE_09] Requests only while selected endpoint and DMA support are both enabled.
// [RULE_10] DMA enable on; when cleared, end after the cycle in progress completes.
// [RULE_11] Interface select pin high forces DMA support off regardless of enable bit.
// [RULE_12] Revision register returns read-only code in bits 3:0; upper bits zero.
// [RULE_13] Node state field codes: 01 wake signalling, 10 active, 11 low power.
// [RULE_14] Bus-reset state entered on reset or by software; disables all endpoint pipes.
// [RULE_15] Firmware clears default-address and address-enable bits around bus-reset state.
// [RULE_16] Wake-signalling state drives resume K onto the bus.
// [RULE_17] Firmware holds wake-signalling state between 1 ms and 15 ms.
// [RULE_18] Firmware moves active node to low power after a suspend event.
// [RULE_19] Low power suspends transceivers and freezes endpoint controllers and state.
// [RULE_20] Bus activity while suspended sets resume-detected flag; software returns active.
// [RULE_21] Warning summary set by any unmasked warning event; cleared by reading warning events.
// [RULE_22] Code 00 selects bus reset; node stays reset at least 100 us.
// [RULE_23] DMA request is one level, evaluated every clock; none for reserved codes.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

module ndsc_top
#(
   parameter int BUS_RESET_CYC = ndsc_pkg::BUS_RESET_MIN_CYC,
   parameter logic [3:0] REV_CODE = ndsc_pkg::REV_CODE_DEFAULT
)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ndsc_pkg::ndsc_ep_s ep_status,
   input wire logic dma_ack,
   input wire logic interface_select_pin,
   input wire logic bus_activity,
   input wire logic div_clk_src,
   output logic dma_req,
   output logic divided_clock_pin,
   output logic endpoint_pipes_off,
   output logic resume_k_drive,
   output logic xcvr_suspend,
   output logic endpoint_freeze
);

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   function automatic logic sel_legal(input logic [2:0] sel);
      sel_legal = (sel <= ndsc_pkg::SEL_LAST_LEGAL);
   endfunction : sel_legal

   function automatic logic [1:0] sel_pair(input logic [2:0] sel);
      sel_pair = sel[2:1];
   endfunction : sel_pair

   // Bus-reset dwell limit
   localparam int CNT_W = 32;
   localparam logic [CNT_W-1:0] RESET_HOLD = CNT_W'(BUS_RESET_CYC);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic mode_meta_r;
   logic mode_sync_r;

   // Bus activity pin
   logic act_meta_r;
   logic act_sync_r;
   logic act_prev_r;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_meta_r <= 1'b0;
         mode_sync_r <= 1'b0;
         act_meta_r <= 1'b0;
         act_sync_r <= 1'b0;
         act_prev_r <= 1'b0;
      end
      else
      begin
         mode_meta_r <= interface_select_pin;
         mode_sync_r <= mode_meta_r;
         act_meta_r <= bus_activity;
         act_sync_r <= act_meta_r;
         act_prev_r <= act_sync_r;
      end
   end

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;

   // Software-visible state
   logic [7:0] dma_control_r;
   logic clk_dis_r;
   logic [5:0] warn_ev_r;
   logic [5:0] warn_mask_r;
   logic warn_sum_r;
   logic resume_flag_r;
   logic pend_valid_r;
   logic [1:0] pend_code_r;
   ndsc_pkg::ndsc_state_e state_r;
   ndsc_pkg::ndsc_state_e state_nxt;

   // Phase decode
   wire setup_ph = psel & ~penable & ~pready_r;
   wire done_ph = psel & penable & pready_r;

   // Address decode
   wire [7:0] word_ofs = {paddr[7:2], 2'b00};
   wire addr_hi_zero = (paddr[31:8] == 24'h000000) & (paddr[1:0] == 2'b00);
   wire hit_dma = addr_hi_zero & (word_ofs == ndsc_pkg::OFS_DMA_CONTROL);
   wire hit_rev = addr_hi_zero & (word_ofs == ndsc_pkg::OFS_REVISION);
   wire hit_node = addr_hi_zero & (word_ofs == ndsc_pkg::OFS_NODE_STATE);
   wire hit_main = addr_hi_zero & (word_ofs == ndsc_pkg::OFS_MAIN_EVENT);
   wire hit_clk = addr_hi_zero & (word_ofs == ndsc_pkg::OFS_CLOCK_CONFIG);
   wire hit_wev = addr_hi_zero & (word_ofs == ndsc_pkg::OFS_WARN_EVENT);
   wire hit_wmsk = addr_hi_zero & (word_ofs == ndsc_pkg::OFS_WARN_MASK);
   wire hit_stat = addr_hi_zero & (word_ofs == ndsc_pkg::OFS_NODE_STATUS);
   wire hit_any = hit_dma | hit_rev | hit_node | hit_main | hit_clk | hit_wev | hit_wmsk | hit_stat;

   // Qualified access strobes
   wire wr_ok = done_ph & pwrite & ~pslverr_r & pstrb[0];
   wire rd_ok = done_ph & ~pwrite & ~pslverr_r;

   // Register strobes
   wire wr_dma = wr_ok & hit_dma;
   wire wr_node = wr_ok & hit_node;
   wire wr_clk = wr_ok & hit_clk;
   wire wr_wmsk = wr_ok & hit_wmsk;
   wire rd_wev = rd_ok & hit_wev;
   wire rd_stat = rd_ok & hit_stat;

   // Read mux; write-only node state reads zero
   logic [7:0] rd_byte;
   always_comb
   begin
      rd_byte = 8'h00;
      if (hit_dma)
         rd_byte = dma_control_r;
      else if (hit_rev)
         rd_byte = {4'h0, REV_CODE}; // RULE_12
      else if (hit_main)
         rd_byte = {7'h00, warn_sum_r};
      else if (hit_clk)
         rd_byte = {clk_dis_r, 7'h00};
      else if (hit_wev)
         rd_byte = {2'b00, warn_ev_r};
      else if (hit_wmsk)
         rd_byte = {2'b00, warn_mask_r};
      else if (hit_stat)
         rd_byte = {state_r, 1'b0, pend_valid_r, dma_req, resume_flag_r};
      else
         rd_byte = 8'h00;
   end

   // No wait state; read data and status come from flip-flops loaded in the setup cycle
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end
      else
      begin
         pready_r <= setup_ph;
         pslverr_r <= setup_ph & ~hit_any;
         if (setup_ph)
            prdata_r <= (hit_any & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   // Write image; reserved bits read zero
   logic [7:0] dma_ctl_wr;
   always_comb
   begin
      dma_ctl_wr = 8'h00;
      dma_ctl_wr[ndsc_pkg::DMA_ON_BIT] = pwdata[ndsc_pkg::DMA_ON_BIT];
      dma_ctl_wr[ndsc_pkg::DMA_TIMING_BIT] = pwdata[ndsc_pkg::DMA_TIMING_BIT];
      dma_ctl_wr[ndsc_pkg::DMA_SEL_MSB:ndsc_pkg::DMA_SEL_LSB] = pwdata[ndsc_pkg::DMA_SEL_MSB:ndsc_pkg::DMA_SEL_LSB];
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         dma_control_r <= ndsc_pkg::DMA_CONTROL_RST; // RULE_02
         clk_dis_r <= 1'b0;
         warn_mask_r <= ndsc_pkg::WARN_MASK_RST;
      end
      else
      begin
         if (wr_dma)
            dma_control_r <= dma_ctl_wr;
         if (wr_clk)
            clk_dis_r <= pwdata[ndsc_pkg::CLK_DIS_BIT];
         if (wr_wmsk)
            warn_mask_r <= pwdata[5:0];
      end
   end

   // ---------------------------------------------------------------
   // Warning events and summary
   // ---------------------------------------------------------------
   logic [5:0] warn_prev_r;

   // New warnings and clear-on-read
   wire [5:0] warn_rise = ep_status.fifo_warn & ~warn_prev_r;
   wire [5:0] warn_ev_nxt = (rd_wev ? 6'h00 : warn_ev_r) | warn_rise;
   wire warn_sum_nxt = (rd_wev ? 1'b0 : warn_sum_r) | (|(warn_rise & warn_mask_r));

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         warn_prev_r <= 6'h00;
         warn_ev_r <= 6'h00;
         warn_sum_r <= 1'b0;
      end
      else
      begin
         warn_prev_r <= ep_status.fifo_warn;
         warn_ev_r <= warn_ev_nxt;
         warn_sum_r <= warn_sum_nxt; // RULE_21
      end
   end

   // ---------------------------------------------------------------
   // Node functional state
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] reset_cnt_r;
   wire in_bus_reset = (state_r == ndsc_pkg::NDSC_BUS_RESET);
   wire in_low_power = (state_r == ndsc_pkg::NDSC_LOW_POWER);

   // Pending state request
   wire reset_held = (reset_cnt_r >= RESET_HOLD);
   wire [1:0] req_code = wr_node ? pwdata[1:0] : pend_code_r;
   wire req_valid = wr_node | pend_valid_r;
   wire go_now = req_valid & (~in_bus_reset | reset_held | (req_code == ndsc_pkg::NS_BUS_RESET)); // RULE_22

   always_comb
   begin
      state_nxt = state_r;
      if (go_now)
      begin
         case (req_code) // RULE_13
            ndsc_pkg::NS_BUS_RESET: state_nxt = ndsc_pkg::NDSC_BUS_RESET; // RULE_14
            ndsc_pkg::NS_WAKE: state_nxt = ndsc_pkg::NDSC_WAKE;
            ndsc_pkg::NS_ACTIVE: state_nxt = ndsc_pkg::NDSC_ACTIVE;
            ndsc_pkg::NS_LOW_POWER: state_nxt = ndsc_pkg::NDSC_LOW_POWER;
            default: state_nxt = state_r;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r <= ndsc_pkg::NDSC_BUS_RESET; // RULE_14
         pend_valid_r <= 1'b0;
         pend_code_r <= ndsc_pkg::NS_BUS_RESET;
         reset_cnt_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         pend_valid_r <= req_valid & ~go_now;
         if (wr_node)
            pend_code_r <= pwdata[1:0];
         if (state_nxt != ndsc_pkg::NDSC_BUS_RESET || state_r != ndsc_pkg::NDSC_BUS_RESET)
            reset_cnt_r <= '0;
         else if (!reset_held)
            reset_cnt_r <= reset_cnt_r + CNT_W'(1); // RULE_22
      end
   end

   // Resume-detected flag; the set wins over a clearing read
   wire act_rise = act_sync_r & ~act_prev_r;
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         resume_flag_r <= 1'b0;
      else
         resume_flag_r <= (in_low_power & act_rise) | (resume_flag_r & ~rd_stat); // RULE_20
   end

   // ---------------------------------------------------------------
   // DMA request
   // ---------------------------------------------------------------
   wire [2:0] sel = dma_control_r[ndsc_pkg::DMA_SEL_MSB:ndsc_pkg::DMA_SEL_LSB];
   wire timing = dma_control_r[ndsc_pkg::DMA_TIMING_BIT];
   wire dma_on = dma_control_r[ndsc_pkg::DMA_ON_BIT] & ~mode_sync_r; // RULE_11
   wire is_tx = ~sel[0];
   wire [1:0] pair = sel_pair(sel);

   // Selected endpoint status
   wire tx_done = ep_status.tx_done[pair];
   wire tx_final = ep_status.tx_final_cmd[pair];
   wire rx_last = ep_status.rx_last[pair];
   wire rx_empty = ep_status.rx_empty[pair];
   wire ep_warn = ep_status.fifo_warn[sel];
   wire ep_on = ep_status.ep_enabled[sel];

   // Request conditions per timing mode
   wire tx_cmpl_req = tx_done & ~tx_final; // RULE_03 RULE_05
   wire tx_warn_req = ep_warn & ~tx_done; // RULE_04 RULE_06
   wire rx_cmpl_req = rx_last & ~rx_empty; // RULE_07
   wire rx_warn_req = ep_warn & ~rx_empty; // RULE_08
   wire cond_tx = timing ? tx_warn_req : tx_cmpl_req;
   wire cond_rx = timing ? rx_warn_req : rx_cmpl_req;

   // Endpoint, enable and power gating
   wire cond = sel_legal(sel) & (is_tx ? cond_tx : cond_rx); // RULE_23
   wire cycle_busy = dma_req & dma_ack;
   wire req_nxt = cond & ep_on & ~in_low_power & (dma_on | cycle_busy); // RULE_09 RULE_10 RULE_19

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         dma_req <= 1'b0;
         divided_clock_pin <= 1'b0;
         endpoint_pipes_off <= 1'b1;
         resume_k_drive <= 1'b0;
         xcvr_suspend <= 1'b0;
         endpoint_freeze <= 1'b0;
      end
      else
      begin
         dma_req <= req_nxt; // RULE_23
         if (!clk_dis_r)
            divided_clock_pin <= div_clk_src; // RULE_01
         endpoint_pipes_off <= (state_nxt == ndsc_pkg::NDSC_BUS_RESET); // RULE_14
         resume_k_drive <= (state_nxt == ndsc_pkg::NDSC_WAKE); // RULE_16
         xcvr_suspend <= (state_nxt == ndsc_pkg::NDSC_LOW_POWER); // RULE_19
         endpoint_freeze <= (state_nxt == ndsc_pkg::NDSC_LOW_POWER); // RULE_19
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

endmodule : ndsc_top

`default_nettype wire

// ===== tb/ndsc_top_sva.sv
// Concurrent checks on the ports of the node DMA and state control block.
// Assumes one mclk domain with asynchronous active-low reset nrst.
`timescale 1ns/10ps
`default_nettype none

module ndsc_top_sva
#(
   parameter int BUS_RESET_CYC = 16,
   parameter logic [3:0] REV_CODE = 4'h0
)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire ndsc_pkg::ndsc_ep_s ep_status,
   input wire logic dma_ack,
   input wire logic interface_select_pin,
   input wire logic div_clk_src,
   input wire logic dma_req,
   input wire logic divided_clock_pin,
   input wire logic endpoint_pipes_off,
   input wire logic resume_k_drive,
   input wire logic xcvr_suspend,
   input wire logic endpoint_freeze
);
   // ---------------------------------------------------------------
   // Bus-reset dwell counter
   // ---------------------------------------------------------------
   logic [31:0] rst_cnt_r;
   always_ff @(posedge mclk or negedge nrst)
      if (!nrst)
         rst_cnt_r <= 32'h0;
      else
         rst_cnt_r <= endpoint_pipes_off ? rst_cnt_r + 32'h1 : 32'h0;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   clk_copy_a: assert property (
      divided_clock_pin != $past(divided_clock_pin) |-> divided_clock_pin == $past(div_clk_src))
      else $error("clock pin left its source");
   state_onehot_a: assert property ($onehot0({endpoint_pipes_off, resume_k_drive, xcvr_suspend}))
      else $error("two node states at once");
   reset_entry_a: assert property ($rose(nrst) |-> endpoint_pipes_off[*4])
      else $error("bus reset state not entered");
   freeze_pair_a: assert property (xcvr_suspend == endpoint_freeze)
      else $error("suspend and freeze differ");
   lowpwr_noreq_a: assert property (xcvr_suspend[*2] |-> !dma_req)
      else $error("request in low power");
   serial_noreq_a: assert property ((interface_select_pin && !dma_ack)[*5] |-> !dma_req)
      else $error("request in serial mode");
   ep_off_a: assert property ((ep_status.ep_enabled == 6'h00 && !dma_ack)[*2] |-> !dma_req)
      else $error("request with endpoints off");
   rev_read_a: assert property (
      pready && !pwrite && !pslverr && paddr == {24'h0, ndsc_pkg::OFS_REVISION} |-> prdata == {28'h0, REV_CODE})
      else $error("bad revision read");
   reset_hold_a: assert property ($fell(endpoint_pipes_off) |-> rst_cnt_r >= BUS_RESET_CYC - 1)
      else $error("bus reset left too early");
endmodule : ndsc_top_sva

bind ndsc_top ndsc_top_sva #(.BUS_RESET_CYC(BUS_RESET_CYC), .REV_CODE(REV_CODE)) sva_u
(
   .mclk, .nrst, .pwrite, .paddr, .prdata, .pready, .pslverr, .ep_status, .dma_ack,
   .interface_select_pin, .div_clk_src, .dma_req, .divided_clock_pin, .endpoint_pipes_off,
   .resume_k_drive, .xcvr_suspend, .endpoint_freeze
);
`default_nettype wire

// ===== tb/ndsc_dma_partner.sv
// External DMA controller model answering the request line.
// Assumes dma_req on mclk; lag sets how many request cycles pass before a cycle starts.
`timescale 1ns/10ps
`default_nettype none

module ndsc_dma_partner
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic dma_req,
   input wire logic [3:0] lag,
   output logic dma_ack
);
   logic [3:0] wait_r;
   logic [1:0] run_r;
   always_ff @(posedge mclk or negedge nrst)
      if (!nrst)
      begin
         wait_r <= 4'h0;
         run_r <= 2'h0;
         dma_ack <= 1'b0;
      end
      else if (run_r != 2'h0)
      begin
         // Cycle runs to its end
         run_r <= run_r - 2'h1;
         dma_ack <= (run_r != 2'h1);
      end
      else if (dma_req && wait_r >= lag)
      begin
         run_r <= 2'h2;
         dma_ack <= 1'b1;
         wait_r <= 4'h0;
      end
      else
         wait_r <= dma_req ? wait_r + 4'h1 : 4'h0;
endmodule : ndsc_dma_partner
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the node DMA and state control block.
// Assumes ndsc_pkg, the design, the checker and the DMA model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb;
   // ---------------------------------------------------------------
   // Stimulus and observation
   // ---------------------------------------------------------------
   localparam int RST_CYC = 16;
   localparam logic [3:0] REV = 4'h3; // Arbitrary revision value
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   ndsc_pkg::ndsc_ep_s ep = '0;
   logic dma_ack;
   logic sel_pin = 1'b0;
   logic bus_act = 1'b0;
   logic div_src = 1'b0;
   logic dma_req;
   logic clk_pin;
   logic pipes_off;
   logic k_drive;
   logic xsusp;
   logic freeze;
   logic [3:0] lag = 4'h1;
   logic [31:0] q;
   logic err;
   int failures = 0;
   int cmp_count = 0;

   always #2.5 mclk = ~mclk;
   always @(posedge mclk) div_src <= ~div_src;

   ndsc_top #(.BUS_RESET_CYC(RST_CYC), .REV_CODE(REV)) dut_u
   (
      .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ep_status(ep), .dma_ack(dma_ack), .interface_select_pin(sel_pin), .bus_activity(bus_act),
      .div_clk_src(div_src), .dma_req(dma_req), .divided_clock_pin(clk_pin),
      .endpoint_pipes_off(pipes_off), .resume_k_drive(k_drive), .xcvr_suspend(xsusp),
      .endpoint_freeze(freeze)
   );

   ndsc_dma_partner dma_u (.mclk(mclk), .nrst(nrst), .dma_req(dma_req), .lag(lag), .dma_ack(dma_ack));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= {24'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      while (pready !== 1'b1) @(posedge mclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic req_is(input logic [7:0] ctl, input ndsc_pkg::ndsc_ep_s e, input logic exp, input string nm);
      apb(1'b1, ndsc_pkg::OFS_DMA_CONTROL, ctl);
      ep <= e;
      repeat (6) @(posedge mclk);
      chk(nm, dma_req, exp);
   endtask : req_is

   task automatic t_regs;
      apb(1'b0, ndsc_pkg::OFS_DMA_CONTROL, 8'h00);
      chk("dma ctl reset", q, 32'h0);
      apb(1'b1, ndsc_pkg::OFS_REVISION, 8'hFF);
      apb(1'b0, ndsc_pkg::OFS_REVISION, 8'h00);
      chk("revision", q, {28'h0, REV});
      apb(1'b0, 8'h40, 8'h00);
      chk("unmapped", err, 1'b1);
      apb(1'b1, ndsc_pkg::OFS_NODE_STATE, 8'h02);
      $display("test regs done");
   endtask : t_regs

   task automatic t_clk;
      logic v;
      apb(1'b1, ndsc_pkg::OFS_CLOCK_CONFIG, 8'h80);
      repeat (2) @(posedge mclk);
      v = clk_pin;
      repeat (5) @(posedge mclk);
      chk("clk frozen", clk_pin, v);
      apb(1'b1, ndsc_pkg::OFS_CLOCK_CONFIG, 8'h00);
      repeat (2) @(posedge mclk);
      v = clk_pin;
      @(posedge mclk);
      chk("clk runs", clk_pin, !v);
      $display("test clock done");
   endtask : t_clk

   task automatic t_warn;
      apb(1'b1, ndsc_pkg::OFS_WARN_MASK, 8'h01);
      ep <= '{3'h0, 3'h0, 3'h0, 3'h0, 6'h02, 6'h3F};
      repeat (3) @(posedge mclk);
      apb(1'b0, ndsc_pkg::OFS_MAIN_EVENT, 8'h00);
      chk("masked warn", q[0], 1'b0);
      ep <= '{3'h0, 3'h0, 3'h0, 3'h0, 6'h03, 6'h3F};
      repeat (3) @(posedge mclk);
      apb(1'b0, ndsc_pkg::OFS_MAIN_EVENT, 8'h00);
      chk("warn sum", q[0], 1'b1);
      apb(1'b0, ndsc_pkg::OFS_WARN_EVENT, 8'h00);
      apb(1'b0, ndsc_pkg::OFS_MAIN_EVENT, 8'h00);
      chk("sum cleared", q[0], 1'b0);
      $display("test warning done");
   endtask : t_warn

   task automatic t_dma;
      for (int s = 0; s < 8; s++)
         req_is(8'h80 | 8'(s), '{3'h7, 3'h0, 3'h7, 3'h0, 6'h00, 6'h3F}, s < 6, "sel");
      req_is(8'h80, '{3'h1, 3'h0, 3'h0, 3'h0, 6'h00, 6'h3E}, 1'b0, "ep off");
      req_is(8'h80, '{3'h1, 3'h0, 3'h0, 3'h0, 6'h00, 6'h3F}, 1'b1, "tx done");
      req_is(8'h80, '{3'h0, 3'h0, 3'h0, 3'h0, 6'h00, 6'h3F}, 1'b0, "tx read");
      req_is(8'h80, '{3'h1, 3'h1, 3'h0, 3'h0, 6'h00, 6'h3F}, 1'b0, "tx final");
      req_is(8'h81, '{3'h0, 3'h0, 3'h1, 3'h0, 6'h00, 6'h3F}, 1'b1, "rx last");
      req_is(8'h81, '{3'h0, 3'h0, 3'h1, 3'h1, 6'h00, 6'h3F}, 1'b0, "rx empty");
      for (int s = 0; s < 6; s++)
         req_is(8'h88 | 8'(s), '{3'h0, 3'h0, 3'h0, 3'h0, 6'(1 << s), 6'h3F}, 1'b1, "warn");
      req_is(8'h88, '{3'h0, 3'h0, 3'h0, 3'h0, 6'h3E, 6'h3F}, 1'b0, "warn gone");
      req_is(8'h88, '{3'h1, 3'h0, 3'h0, 3'h0, 6'h01, 6'h3F}, 1'b0, "warn done");
      req_is(8'h89, '{3'h0, 3'h0, 3'h0, 3'h1, 6'h02, 6'h3F}, 1'b0, "rx warn empty");
      $display("test dma done");
   endtask : t_dma

   task automatic t_en;
      lag <= 4'hF;
      req_is(8'h80, '{3'h1, 3'h0, 3'h0, 3'h0, 6'h00, 6'h3F}, 1'b1, "slow ack");
      apb(1'b1, ndsc_pkg::OFS_DMA_CONTROL, 8'h00);
      repeat (2) @(posedge mclk);
      chk("dma off", dma_req, 1'b0);
      lag <= 4'h1;
      sel_pin <= 1'b1;
      req_is(8'h80, '{3'h1, 3'h0, 3'h0, 3'h0, 6'h00, 6'h3F}, 1'b0, "serial");
      sel_pin <= 1'b0;
      req_is(8'h80, '{3'h1, 3'h0, 3'h0, 3'h0, 6'h00, 6'h3F}, 1'b1, "parallel");
      $display("test enable done");
   endtask : t_en

   task automatic t_state;
      apb(1'b1, ndsc_pkg::OFS_NODE_STATE, 8'h00);
      apb(1'b1, ndsc_pkg::OFS_NODE_STATE, 8'h02);
      apb(1'b0, ndsc_pkg::OFS_NODE_STATUS, 8'h00);
      chk("held reset", {q[7:4], pipes_off}, 5'h03);
      repeat (RST_CYC + 4) @(posedge mclk);
      apb(1'b0, ndsc_pkg::OFS_NODE_STATUS, 8'h00);
      chk("active", {q[7:4], pipes_off}, 5'h08);
      apb(1'b1, ndsc_pkg::OFS_NODE_STATE, 8'h03);
      repeat (3) @(posedge mclk);
      chk("low power", {xsusp, freeze, dma_req, k_drive}, 4'hC);
      bus_act <= 1'b1;
      repeat (6) @(posedge mclk);
      apb(1'b0, ndsc_pkg::OFS_NODE_STATUS, 8'h00);
      chk("resume flag", q[0], 1'b1);
      bus_act <= 1'b0;
      apb(1'b0, ndsc_pkg::OFS_NODE_STATUS, 8'h00);
      chk("flag cleared", q[0], 1'b0);
      apb(1'b1, ndsc_pkg::OFS_NODE_STATE, 8'h02);
      apb(1'b1, ndsc_pkg::OFS_NODE_STATE, 8'h01);
      repeat (2) @(posedge mclk);
      chk("wake", {k_drive, xsusp}, 2'h2);
      apb(1'b1, ndsc_pkg::OFS_NODE_STATE, 8'h00);
      repeat (2) @(posedge mclk);
      chk("pipes off", pipes_off, 1'b1);
      $display("test state done");
   endtask : t_state

   task automatic conclude;
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude

   initial
   begin
      repeat (20000) @(posedge mclk);
      failures++;
      conclude();
   end

   initial
   begin
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      t_regs();
      t_clk();
      t_warn();
      t_dma();
      t_en();
      t_state();
      conclude();
   end
endmodule : tb
`default_nettype wire
